/* File: gpio_pkg.sv */
/*
 Constants, register map and carrier types of the bank B / bank C port block.
 Assumes a single 50 MHz clock and a byte-wide register port.
*/
`default_nettype none
package gpio_pkg;
    // ============================================================
    // Widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SYNC_STAGES = 2;

    // ============================================================
    // Register indices
    localparam logic [3:0] OFF_B_PINS = 4'h0;
    localparam logic [3:0] OFF_B_LATCH = 4'h1;
    localparam logic [3:0] OFF_B_DIR = 4'h2;
    localparam logic [3:0] OFF_IC_MAIN = 4'h3;
    localparam logic [3:0] OFF_IC_SECOND = 4'h4;
    localparam logic [3:0] OFF_IC_THIRD = 4'h5;
    localparam logic [3:0] OFF_ANALOG_CFG = 4'h6;
    localparam logic [3:0] OFF_C_PINS = 4'h7;
    localparam logic [3:0] OFF_C_LATCH = 4'h8;
    localparam logic [3:0] OFF_C_DIR = 4'h9;

    // ============================================================
    // Field positions
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int CHANGE_IE_BIT = 3;
    localparam int PULLUP_DIS_BIT = 7;
    localparam int CAPCMP2_SIGNAL_B_PIN = 3;
    localparam int CAPCMP2_SIGNAL_C_PIN = 1;
    localparam int COMP1_PIN = 5;

    // ============================================================
    // Values after reset
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] IC_MAIN_RST = 8'h00;
    localparam logic [7:0] IC_SECOND_RST = 8'h80;
    localparam logic [7:0] IC_THIRD_RST = 8'h00;
    localparam logic [7:0] ANALOG_ON_RST = 8'h1f;
    localparam logic [7:0] ANALOG_OFF_RST = 8'h00;
    localparam logic [7:0] DEBUG_PIN_MASK = 8'hc0;
    localparam logic [3:0] REF_RST = 4'h0;

    // ============================================================
    // Carrier types
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] dir;
        logic [7:0] data;
    } pin_ovr_s;
endpackage
`default_nettype wire

/* File: sync_stage.sv */
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes the inputs are asynchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_stage #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import gpio_pkg::*;
    logic [W-1:0] meta_reg;

    // ============================================================
    // Two stages; only the second stage is read outside.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: port_drive.sv */
/*
 Registered output driver of one 8-bit port with peripheral overrides.
 Assumes direction 1 means input and an override wins over the port data.
*/
`timescale 1ns/100ps
`default_nettype none
module port_drive (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] dir,
    input wire logic [7:0] latch,
    input wire gpio_pkg::pin_ovr_s ovr,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    import gpio_pkg::*;
    wire [7:0] dir_eff = (ovr.en & ovr.dir) | (~ovr.en & dir);
    wire [7:0] data_eff = (ovr.en & ovr.data) | (~ovr.en & latch);

    // ============================================================
    // Direction 1 floats the pin, 0 drives the selected data.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_out <= LATCH_RST;
            pin_oe <= 8'h00;
        end else if (clk_en) begin
            pin_out <= data_eff; // RULE2
            pin_oe <= ~dir_eff; // RULE2
        end
    end
endmodule
`default_nettype wire

/* File: gpio_bank.sv */
/*
 Bank B and bank C general purpose ports with change detection on B7..B4.
 Assumes a register master on the same clock and pins from outside.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: Two 8-bit banks, direction, latch, pin level.
// RULE2: Direction 1 floats pin; 0 drives latch.
// RULE3: Latch register reads back latched value.
// RULE4: Port read gives pins; write sets latch.
// RULE5: Clearing pull-up disable bit enables pull-ups.
// RULE6: Output pins never get a pull-up.
// RULE7: Pull-ups disabled after power-on reset.
// RULE8: Pins B4..B0 analog at reset if configured.
// RULE9: Analog pins read zero; output unaffected.
// RULE10: Only input pins B7..B4 are compared.
// RULE11: Mismatches ORed into change flag.
// RULE12: Change interrupt wakes from sleep, idle.
// RULE13: Mismatch keeps flag set; port access recaptures.
// RULE14: Software accesses port before clearing flag.
// RULE15: Software avoids polling port during detection.
// RULE16: Capture channel 2 on B3 or C1.
// RULE17: Comparator output overrides latch on B5.
// RULE18: Debug interface takes over pins B6, B7.
// RULE19: Overrides never change stored bank C direction.
// RULE20: Bank C comes up as inputs.
// RULE21: Pin levels synchronised before any use.
module gpio_bank (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [gpio_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic mem_to_mem_move,
    output logic [gpio_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [7:0] bank_b_in,
    output logic [7:0] bank_b_out,
    output logic [7:0] bank_b_oe,
    output logic [7:0] bank_b_pullup,
    input wire logic [7:0] bank_c_in,
    output logic [7:0] bank_c_out,
    output logic [7:0] bank_c_oe,
    input wire logic analog_default_cfg,
    input wire logic capcmp2_pin_select,
    input wire logic in_circuit_debug,
    input wire logic comparator1_sel,
    input wire logic comparator1_output,
    input wire logic capcmp2_out_en,
    input wire logic capcmp2_signal,
    output logic capcmp2_capture_in,
    input wire gpio_pkg::pin_ovr_s bank_c_periph,
    output logic change_wake
);
    import gpio_pkg::*;

    // ============================================================
    // Register state
    logic [7:0] bank_b_output_latch_reg;
    logic [7:0] bank_b_direction_reg;
    logic [7:0] bank_c_latch_reg;
    logic [7:0] bank_c_direction_reg;
    logic [7:0] ic_main_reg;
    logic [7:0] ic_second_reg;
    logic [7:0] ic_third_reg;
    logic [7:0] analog_cfg_reg;
    logic [3:0] ref_reg;
    logic [3:0] ref_next;
    logic [1:0] settle_reg;
    logic change_flag_next;
    logic [7:0] rdata_next;

    // ============================================================
    // Synchronised pin levels
    logic [7:0] b_sync;
    logic [7:0] c_sync;

    sync_stage #(
        .W(8)
    ) u_sync_b (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(bank_b_in), // RULE21
        .sync_out(b_sync)
    );

    sync_stage #(
        .W(8)
    ) u_sync_c (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(bank_c_in), // RULE21
        .sync_out(c_sync)
    );

    // ============================================================
    // Address decode
    wire wr_b_pins = reg_wr && (reg_addr == OFF_B_PINS);
    wire wr_b_latch = reg_wr && (reg_addr == OFF_B_LATCH);
    wire wr_b_dir = reg_wr && (reg_addr == OFF_B_DIR);
    wire wr_ic_main = reg_wr && (reg_addr == OFF_IC_MAIN);
    wire wr_ic_second = reg_wr && (reg_addr == OFF_IC_SECOND);
    wire wr_ic_third = reg_wr && (reg_addr == OFF_IC_THIRD);
    wire wr_analog = reg_wr && (reg_addr == OFF_ANALOG_CFG);
    wire wr_c_pins = reg_wr && (reg_addr == OFF_C_PINS);
    wire wr_c_latch = reg_wr && (reg_addr == OFF_C_LATCH);
    wire wr_c_dir = reg_wr && (reg_addr == OFF_C_DIR);
    wire rd_b_pins = reg_rd && (reg_addr == OFF_B_PINS);

    // ============================================================
    // Digital input view of bank B
    wire dbg_on = in_circuit_debug;
    wire [7:0] dbg_mask = dbg_on ? DEBUG_PIN_MASK : 8'h00; // RULE18
    wire [7:0] analog_mask = {3'h0, analog_cfg_reg[4:0]};
    wire [7:0] b_digital = b_sync & ~analog_mask & ~dbg_mask; // RULE9

    // ============================================================
    // Change detection on B7..B4
    wire [3:0] cmp_mask = bank_b_direction_reg[7:4] & ~dbg_mask[7:4]; // RULE10
    wire [3:0] pin_diff = (b_digital[7:4] ^ ref_reg) & cmp_mask;
    // The reference follows the pins until the synchronisers hold real levels.
    wire settled = (settle_reg == 2'(SYNC_STAGES + 1)); // RULE21
    wire mismatch = settled && (|pin_diff); // RULE11
    wire port_access = wr_b_pins || (rd_b_pins && !mem_to_mem_move); // RULE13
    wire change_flag = ic_main_reg[CHANGE_FLAG_BIT];
    wire change_irq_enable = ic_main_reg[CHANGE_IE_BIT];
    wire pullup_disable_n = ic_second_reg[PULLUP_DIS_BIT];

    assign ref_next = (port_access || !settled) ? b_digital[7:4] : ref_reg; // RULE13

    // Hardware set wins over a software clear in the same cycle.
    assign change_flag_next = mismatch
        || (wr_ic_main ? reg_wdata[CHANGE_FLAG_BIT] : change_flag); // RULE14

    assign change_wake = change_flag && change_irq_enable; // RULE12

    // ============================================================
    // Pull-ups
    wire [7:0] pull_allow = bank_b_direction_reg & ~dbg_mask; // RULE6
    assign bank_b_pullup = pullup_disable_n ? 8'h00 : pull_allow; // RULE5

    // ============================================================
    // Peripheral overrides
    wire ccp_on_b = capcmp2_out_en && !capcmp2_pin_select; // RULE16
    wire ccp_on_c = capcmp2_out_en && capcmp2_pin_select; // RULE16
    wire comp_on_b = comparator1_sel && !bank_b_direction_reg[COMP1_PIN];
    pin_ovr_s b_ovr;
    pin_ovr_s c_ovr;

    assign b_ovr.en = dbg_mask
        | ({7'h0, comp_on_b} << COMP1_PIN) // RULE17
        | ({7'h0, ccp_on_b} << CAPCMP2_SIGNAL_B_PIN);
    assign b_ovr.dir = dbg_mask | bank_b_direction_reg;
    assign b_ovr.data = ({7'h0, comparator1_output} << COMP1_PIN)
        | ({7'h0, capcmp2_signal} << CAPCMP2_SIGNAL_B_PIN);

    wire [7:0] c_ccp_en = {7'h0, ccp_on_c} << CAPCMP2_SIGNAL_C_PIN;
    wire [7:0] c_ccp_data = {7'h0, capcmp2_signal} << CAPCMP2_SIGNAL_C_PIN;
    assign c_ovr.en = bank_c_periph.en | c_ccp_en; // RULE19
    assign c_ovr.dir = (bank_c_periph.en & bank_c_periph.dir)
        | (~bank_c_periph.en & bank_c_direction_reg);
    assign c_ovr.data = (bank_c_periph.en & bank_c_periph.data)
        | (~bank_c_periph.en & c_ccp_data);

    assign capcmp2_capture_in = capcmp2_pin_select
        ? c_sync[CAPCMP2_SIGNAL_C_PIN] : b_digital[CAPCMP2_SIGNAL_B_PIN]; // RULE16

    // ============================================================
    // Pin drivers
    port_drive u_drive_b (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .dir(bank_b_direction_reg), // RULE1
        .latch(bank_b_output_latch_reg),
        .ovr(b_ovr),
        .pin_out(bank_b_out),
        .pin_oe(bank_b_oe)
    );

    port_drive u_drive_c (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .dir(bank_c_direction_reg), // RULE1
        .latch(bank_c_latch_reg),
        .ovr(c_ovr),
        .pin_out(bank_c_out),
        .pin_oe(bank_c_oe)
    );

    // ============================================================
    // Read multiplexer
    always_comb begin
        unique case (reg_addr)
            OFF_B_PINS: rdata_next = b_digital; // RULE4
            OFF_B_LATCH: rdata_next = bank_b_output_latch_reg; // RULE3
            OFF_B_DIR: rdata_next = bank_b_direction_reg;
            OFF_IC_MAIN: rdata_next = ic_main_reg;
            OFF_IC_SECOND: rdata_next = ic_second_reg;
            OFF_IC_THIRD: rdata_next = ic_third_reg;
            OFF_ANALOG_CFG: rdata_next = analog_cfg_reg;
            OFF_C_PINS: rdata_next = c_sync;
            OFF_C_LATCH: rdata_next = bank_c_latch_reg;
            OFF_C_DIR: rdata_next = bank_c_direction_reg; // RULE19
            default: rdata_next = 8'h00;
        endcase
    end

    // ============================================================
    // Bank registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bank_b_output_latch_reg <= LATCH_RST;
            bank_b_direction_reg <= DIR_RST;
            bank_c_latch_reg <= LATCH_RST;
            bank_c_direction_reg <= DIR_RST; // RULE20
        end else if (clk_en) begin
            if (wr_b_pins || wr_b_latch) begin
                bank_b_output_latch_reg <= reg_wdata; // RULE4
            end
            if (wr_b_dir) begin
                bank_b_direction_reg <= reg_wdata;
            end
            if (wr_c_pins || wr_c_latch) begin
                bank_c_latch_reg <= reg_wdata;
            end
            if (wr_c_dir) begin
                bank_c_direction_reg <= reg_wdata;
            end
        end
    end

    // ============================================================
    // Control registers and change reference
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ic_main_reg <= IC_MAIN_RST;
            ic_second_reg <= IC_SECOND_RST; // RULE7
            ic_third_reg <= IC_THIRD_RST;
            analog_cfg_reg <= analog_default_cfg
                ? ANALOG_ON_RST : ANALOG_OFF_RST; // RULE8
            ref_reg <= REF_RST;
            settle_reg <= '0;
        end else if (clk_en) begin
            if (!settled) begin
                settle_reg <= settle_reg + 2'h1;
            end
            if (wr_ic_main) begin
                ic_main_reg[7:1] <= reg_wdata[7:1];
            end
            ic_main_reg[CHANGE_FLAG_BIT] <= change_flag_next; // RULE11
            if (wr_ic_second) begin
                ic_second_reg <= reg_wdata;
            end
            if (wr_ic_third) begin
                ic_third_reg <= reg_wdata;
            end
            if (wr_analog) begin
                analog_cfg_reg <= reg_wdata;
            end
            ref_reg <= ref_next;
        end
    end

    // ============================================================
    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_next : 8'h00;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_dir_drive: assert property (clk_en && !b_ovr.en[0] // RULE2
        |=> bank_b_oe[0] == !$past(bank_b_direction_reg[0]))
        else $error("bank B pin 0 enable does not follow direction");

    a_latch_read: assert property (clk_en && reg_rd // RULE3
        && reg_addr == OFF_B_LATCH
        |=> reg_rdata == $past(bank_b_output_latch_reg))
        else $error("latch read does not return latch");

    a_pin_read: assert property (clk_en && rd_b_pins // RULE4
        |=> reg_rdata == $past(b_digital))
        else $error("port read does not return pin levels");

    a_pullup_on: assert property (!pullup_disable_n && !dbg_on // RULE5
        |-> bank_b_pullup == bank_b_direction_reg)
        else $error("pull-ups not enabled on inputs");

    a_pullup_out: assert property ((bank_b_pullup & ~bank_b_direction_reg) // RULE6
        == 8'h00)
        else $error("pull-up on an output pin");

    a_por_pullup: assert property (disable iff (1'b0) // RULE7
        sys_rst |=> bank_b_pullup == 8'h00)
        else $error("pull-ups active after reset");

    a_analog_zero: assert property ((b_digital & analog_mask) == 8'h00) // RULE9
        else $error("analog pin reads nonzero");

    a_out_excluded: assert property (bank_b_direction_reg[7:4] == 4'h0 |-> !mismatch) // RULE10
        else $error("output pin caused mismatch");

    a_flag_set: assert property (clk_en && mismatch // RULE11
        |=> change_flag)
        else $error("mismatch did not set change flag");

    a_ref_capture: assert property (clk_en && port_access // RULE13
        |=> ref_reg == $past(b_digital[7:4]))
        else $error("port access did not recapture reference");

    a_mm_keep: assert property (clk_en && rd_b_pins && mem_to_mem_move // RULE13
        && !reg_wr && settled |=> $stable(ref_reg))
        else $error("move read recaptured reference");

    a_ccp_route: assert property (capcmp2_pin_select // RULE16
        |-> capcmp2_capture_in == c_sync[CAPCMP2_SIGNAL_C_PIN])
        else $error("capture channel misrouted");

    a_dbg_pins: assert property (clk_en && dbg_on // RULE18
        |=> bank_b_oe[7:6] == 2'h0)
        else $error("debug pins driven by port");

    a_wake: assert property (change_flag && change_irq_enable // RULE12
        |-> change_wake)
        else $error("wake missing");

    c_change: cover property (clk_en && mismatch ##1 change_flag);
    c_clear: cover property (port_access ##1 wr_ic_main && !mismatch);
    c_comp: cover property (comp_on_b ##1 clk_en);
    c_wake: cover property (change_wake);
endmodule
`default_nettype wire

/* File: pin_keypad_model.sv */
/*
 External circuitry on the bank B and bank C pins, such as a keypad.
 Assumes the testbench chooses which bank B pins it drives and to what level.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_keypad_model (
    input wire logic clock,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] b_pullup,
    input wire logic [7:0] b_ext_en,
    input wire logic [7:0] b_ext_val,
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe,
    input wire logic [7:0] c_ext_val,
    output logic [7:0] b_level,
    output logic [7:0] c_level
);
    // ============================================================
    // Floating lines change every cycle so no stale level survives.
    logic [7:0] float_reg = 8'h55;
    always @(posedge clock) begin
        float_reg <= ~float_reg;
    end

    // ============================================================
    // Wire resolution: device drive, then keypad, then pull-up.
    assign b_level = (b_oe & b_out) | (~b_oe & b_ext_en & b_ext_val)
        | (~b_oe & ~b_ext_en & b_pullup) | (~b_oe & ~b_ext_en & ~b_pullup & float_reg);
    assign c_level = (c_oe & c_out) | (~c_oe & c_ext_val);
endmodule
`default_nettype wire

/* File: gpio_bank_b_c_change_irq_tb_top.sv */
/*
 Self-checking testbench of the bank B / bank C port block.
 Assumes the block and the pin model are compiled beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module gpio_bank_b_c_change_irq_tb_top;
    import gpio_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic move = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_rdata, b_in, b_out, b_oe, b_pull, c_in, c_out, c_oe;
    logic cfg = 1'b1, ccp_sel = 1'b0, dbg = 1'b0, cmp_sel = 1'b0, cmp_out = 1'b0;
    logic ccp_en = 1'b0, ccp_sig = 1'b0, cap_in, wake;
    logic [7:0] ext_en = 8'hff, ext_b = 8'hff, ext_c = 8'ha5;
    pin_ovr_s c_periph = '0;
    int errors = 0;
    int n_tests = 0;

    // ============================================================
    // Clock, design and pins
    always #10 clock = ~clock;
    gpio_bank dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .mem_to_mem_move(move),
        .reg_rdata(reg_rdata), .bank_b_in(b_in), .bank_b_out(b_out), .bank_b_oe(b_oe),
        .bank_b_pullup(b_pull), .bank_c_in(c_in), .bank_c_out(c_out), .bank_c_oe(c_oe),
        .analog_default_cfg(cfg), .capcmp2_pin_select(ccp_sel), .in_circuit_debug(dbg),
        .comparator1_sel(cmp_sel), .comparator1_output(cmp_out), .capcmp2_out_en(ccp_en),
        .capcmp2_signal(ccp_sig), .capcmp2_capture_in(cap_in), .bank_c_periph(c_periph),
        .change_wake(wake));
    pin_keypad_model pins_u (.clock(clock), .b_out(b_out), .b_oe(b_oe), .b_pullup(b_pull),
        .b_ext_en(ext_en), .b_ext_val(ext_b), .c_out(c_out), .c_oe(c_oe),
        .c_ext_val(ext_c), .b_level(b_in), .c_level(c_in));

    // ============================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic mv, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        move <= mv;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        move <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, 1'b0, d);
        chk(d, exp);
    endtask
    task automatic pins(input logic [7:0] en, input logic [7:0] b);
        @(posedge clock);
        ext_en <= en;
        ext_b <= b;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge clock);
        sys_rst <= 1'b1;
        cfg <= strap;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        tick(1);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        do_reset(1'b1);
        rdchk(OFF_B_DIR, DIR_RST);
        rdchk(OFF_B_LATCH, LATCH_RST);
        rdchk(OFF_IC_SECOND, IC_SECOND_RST);
        rdchk(OFF_IC_MAIN, IC_MAIN_RST);
        chk(b_pull, 8'h00);
        chk(b_oe, 8'h00);
        rdchk(OFF_ANALOG_CFG, ANALOG_ON_RST);
        rdchk(OFF_B_PINS, 8'he0);
        rdchk(OFF_C_DIR, DIR_RST);
        rdchk(OFF_C_PINS, 8'ha5);
        chk(c_oe, 8'h00);
        do_reset(1'b0);
        rdchk(OFF_ANALOG_CFG, ANALOG_OFF_RST);
        rdchk(OFF_B_PINS, 8'hff);
        wr(4'hc, 8'hff);
        rdchk(4'hc, 8'h00);
    endtask
    task automatic t_drive();
        pins(8'h0f, 8'h03);
        wr(OFF_ANALOG_CFG, 8'h10);
        wr(OFF_B_DIR, 8'h0f);
        wr(OFF_B_PINS, 8'h5a);
        tick(4);
        chk(b_oe, 8'hf0);
        chk(b_out & b_oe, 8'h50);
        rdchk(OFF_B_LATCH, 8'h5a);
        rdchk(OFF_B_PINS, 8'h43);
        wr(OFF_IC_SECOND, 8'h00);
        tick(1);
        chk(b_pull, 8'h0f);
        @(posedge clock);
        dbg <= 1'b1;
        tick(2);
        chk(b_oe, 8'h30);
        @(posedge clock);
        dbg <= 1'b0;
    endtask
    task automatic t_override();
        @(posedge clock);
        cmp_sel <= 1'b1;
        cmp_out <= 1'b1;
        tick(2);
        chk(b_out & b_oe, 8'h70);
        pins(8'h0f, 8'h0b);
        tick(4);
        chk({7'h00, cap_in}, 8'h01);
        @(posedge clock);
        ccp_sel <= 1'b1;
        c_periph <= {8'h01, 8'h00, 8'h01};
        tick(2);
        chk({7'h00, cap_in}, 8'h00);
        chk(c_oe, 8'h01);
        wr(OFF_C_DIR, 8'hfd);
        @(posedge clock);
        ccp_en <= 1'b1;
        ccp_sig <= 1'b1;
        tick(2);
        chk(c_out & c_oe, 8'h03);
        rdchk(OFF_C_DIR, 8'hfd);
    endtask
    task automatic t_change();
        logic [7:0] d;
        @(posedge clock);
        cmp_sel <= 1'b0;
        c_periph <= '0;
        pins(8'hff, 8'h00);
        wr(OFF_B_DIR, 8'h7f);
        wr(OFF_B_PINS, 8'h00);
        tick(4);
        rd(OFF_B_PINS, 1'b0, d);
        wr(OFF_IC_MAIN, 8'h08);
        pins(8'hff, 8'h08);
        wr(OFF_B_LATCH, 8'h80);
        tick(5);
        rdchk(OFF_IC_MAIN, 8'h08);
        pins(8'hff, 8'h48);
        tick(5);
        rdchk(OFF_IC_MAIN, 8'h09);
        chk({7'h00, wake}, 8'h01);
        rd(OFF_B_PINS, 1'b1, d);
        wr(OFF_IC_MAIN, 8'h08);
        tick(2);
        rdchk(OFF_IC_MAIN, 8'h09);
        rdchk(OFF_B_PINS, 8'hc8);
        wr(OFF_IC_MAIN, 8'h08);
        tick(2);
        rdchk(OFF_IC_MAIN, 8'h08);
        chk({7'h00, wake}, 8'h00);
        pins(8'hff, 8'h68);
        tick(5);
        wr(OFF_B_PINS, 8'h80);
        wr(OFF_IC_MAIN, 8'h08);
        tick(2);
        rdchk(OFF_IC_MAIN, 8'h08);
    endtask
    task automatic t_freeze();
        @(posedge clock);
        clk_en <= 1'b0;
        wr(OFF_B_LATCH, 8'h33);
        @(posedge clock);
        clk_en <= 1'b1;
        tick(2);
        chk(b_out & b_oe, 8'h80);
        rdchk(OFF_B_LATCH, 8'h80);
    endtask

    // ============================================================
    // Verdict, main sequence and watchdog
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_drive();
        t_override();
        t_change();
        t_freeze();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
